/* File: core/otp_lock_pkg.sv */
// constants, opcodes and carrier types for the otp lock control block
package otp_lock_pkg;
  // instruction opcodes
  localparam logic [7:0] OP_OTP_ENTER   = 8'hB1;
  localparam logic [7:0] OP_OTP_EXIT    = 8'hC1;
  localparam logic [7:0] OP_LOCK_READ   = 8'h2B;
  localparam logic [7:0] OP_LOCK_WRITE  = 8'h2F;
  // frame bit counts
  localparam logic [4:0] BITS_OPCODE    = 5'h08;
  localparam logic [4:0] BITS_LOCK_WR   = 5'h10;
  localparam logic [4:0] BITS_MAX       = 5'h1F;
  localparam logic [4:0] STEP_SINGLE    = 5'h01;
  localparam logic [4:0] STEP_QUAD      = 5'h04;
  // lock-status register layout
  localparam int         FACTORY_BIT    = 0;
  localparam int         CUST_LOCK_BIT  = 1;
  localparam logic [5:0] RESERVED_READ  = 6'h00;
  // otp address map
  localparam logic [23:0] OTP_SERIAL_LAST = 24'h00_000F;
  localparam logic [23:0] OTP_AREA_LAST   = 24'h00_01FF;

  // serial lines as sampled on each shift clock
  typedef struct packed {
    logic       cs_n;
    logic       strobe;
    logic [3:0] data;
  } serial_in_s;

  // permissions handed to the general read/program machinery
  typedef struct packed {
    logic otp_mode;
    logic array_write_block;
    logic status_write_block;
    logic otp_program_allow;
  } gate_s;

  typedef enum logic [1:0] {
    ST_OPCODE,
    ST_LOCK_READ,
    ST_LOCK_WRITE,
    ST_OTHER
  } frame_e;
endpackage : otp_lock_pkg

/* File: core/otp_lock_control.sv */
// otp mode and lock-status control at the instruction level
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - enter opcode switches the device into otp access mode.
// - exit opcode returns the device to main array addressing.
// - in otp mode ordinary reads and page programs target the otp area.
// - in otp mode status writes and lock-status writes are refused.
// - once locked by factory or customer, otp programs and erases are ignored.
// - in otp mode every main array write or erase is blocked.
// - lock-status read works any time and repeats while chip select low.
// - bit 0 is a read-only factory lock indicator.
// - lock-status write needs no prior write enable.
// - lock-status write may set customer lock bit 1, then it is permanent.
// - lock-status write executes only when chip select rises after exactly 16 bits (opcode plus one data byte).
// - otp area is serial field 000000-00000F and user region up to 0001FF.
module otp_lock_control (
  // clock and reset
  input  wire logic                      clock_in,
  input  wire logic                      nrst_in,
  // serial instruction stream
  input  wire otp_lock_pkg::serial_in_s  serial_in,
  input  wire logic                      quad_instruction_mode_in,
  // non-volatile lock bits as stored
  input  wire logic                      factory_lock_nv_in,
  input  wire logic                      customer_lock_nv_in,
  // address from the general machinery
  input  wire logic [23:0]               addr_in,
  // serial output
  output logic [3:0]                     sdo_out,
  output logic                           sdo_oe_out,
  // gating and status
  output otp_lock_pkg::gate_s            gate_out,
  output logic                           otp_addr_valid_out,
  output logic                           otp_serial_field_out,
  output logic [7:0]                     otp_lock_status_out,
  output logic                           customer_lock_write_out
);

  otp_lock_pkg::frame_e state_q, state_d;
  logic [4:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] rd_q, rd_d;
  logic [3:0] sdo_q, sdo_d;
  logic       oe_q, oe_d;
  logic       otp_mode_q, otp_mode_d;
  logic       customer_lock_bit_q, customer_lock_bit_d;
  logic       factory_q, factory_d;
  // marks the first edge after reset, when the stored bits are fetched
  logic       loaded_q;
  logic       nv_write_q, nv_write_d;
  logic       addr_valid_q, addr_valid_d;
  logic       serial_field_q, serial_field_d;

  logic [4:0] step;
  logic [4:0] cnt_next;
  logic [7:0] shift_next;
  logic [7:0] lock_status;
  logic       locked;

  assign step        = quad_instruction_mode_in ? otp_lock_pkg::STEP_QUAD
                                                : otp_lock_pkg::STEP_SINGLE;
  // saturate so an overlong frame can never wrap back onto the boundary count
  assign cnt_next    = (cnt_q > otp_lock_pkg::BITS_MAX - step) ? otp_lock_pkg::BITS_MAX
                                                               : cnt_q + step;
  assign shift_next  = quad_instruction_mode_in ? {shift_q[3:0], serial_in.data}
                                                : {shift_q[6:0], serial_in.data[0]};
  // reserved bits read back as zero so the host mask is harmless
  assign lock_status = {otp_lock_pkg::RESERVED_READ, customer_lock_bit_q, factory_q};
  // factory lock blocks programming as firmly as the customer lock
  assign locked      = factory_q | customer_lock_bit_q;

  always_comb begin
    state_d             = state_q;
    cnt_d               = cnt_q;
    shift_d             = shift_q;
    rd_d                = rd_q;
    sdo_d               = sdo_q;
    oe_d                = oe_q;
    otp_mode_d          = otp_mode_q;
    customer_lock_bit_d = customer_lock_bit_q;
    nv_write_d          = 1'b0;
    if (serial_in.cs_n) begin
      // end of frame: a pending lock write executes only on an exact boundary
      // extra bytes push the count past 16 and then saturate it, so they miss the boundary too
      // byte boundary check
      if (state_q == otp_lock_pkg::ST_LOCK_WRITE && cnt_q == otp_lock_pkg::BITS_LOCK_WR
          && !otp_mode_q
          && !customer_lock_bit_q
          && shift_q[otp_lock_pkg::CUST_LOCK_BIT]) begin
        customer_lock_bit_d = 1'b1;
        // the pulse asks the non-volatile store to program bit 1
        nv_write_d          = 1'b1;
      end
      state_d = otp_lock_pkg::ST_OPCODE;
      cnt_d   = '0;
      // output stops on the edge after deselect
      oe_d    = 1'b0;
    end else if (serial_in.strobe) begin
      cnt_d   = cnt_next;
      shift_d = shift_next;
      unique case (state_q)
        otp_lock_pkg::ST_OPCODE: begin
          if (cnt_next == otp_lock_pkg::BITS_OPCODE) begin
            unique case (shift_next)
              otp_lock_pkg::OP_OTP_ENTER: begin
                otp_mode_d = 1'b1;
                state_d    = otp_lock_pkg::ST_OTHER;
              end
              otp_lock_pkg::OP_OTP_EXIT: begin
                otp_mode_d = 1'b0;
                state_d    = otp_lock_pkg::ST_OTHER;
              end
              otp_lock_pkg::OP_LOCK_READ: begin
                // snapshot at decode so each byte reads coherently
                rd_d    = lock_status;
                state_d = otp_lock_pkg::ST_LOCK_READ;
              end
              otp_lock_pkg::OP_LOCK_WRITE: state_d = otp_lock_pkg::ST_LOCK_WRITE;
              // unknown opcodes are left to the general machinery
              default:                     state_d = otp_lock_pkg::ST_OTHER;
            endcase
          end else if (cnt_next > otp_lock_pkg::BITS_OPCODE) begin
            // a count past the opcode without decode means a stray frame
            state_d = otp_lock_pkg::ST_OTHER;
          end
        end
        otp_lock_pkg::ST_LOCK_READ: begin
          oe_d = 1'b1;
          if (quad_instruction_mode_in) begin
            // quad output alternates high and low nibble of the snapshot
            sdo_d = rd_q[7:4];
            rd_d  = (rd_q[3:0] == 4'h0 && rd_q[7:4] == 4'h0) ? lock_status
                                                             : {rd_q[3:0], rd_q[7:4]};
          end else begin
            // rotate so the byte repeats while chip select stays low
            sdo_d = {3'b000, rd_q[7]};
            rd_d  = {rd_q[6:0], rd_q[7]};
          end
        end
        otp_lock_pkg::ST_LOCK_WRITE, otp_lock_pkg::ST_OTHER: ;
      endcase
    end
    // the first edge after reset fetches the stored lock instead of any command
    if (!loaded_q) begin
      customer_lock_bit_d = customer_lock_nv_in;
    end
  end

  // strap-like nv bits are captured by a clocked load after reset release
  always_comb begin
    factory_d      = factory_q;
    // flags are registered, so they lag addr_in by one cycle
    // otp address ranges
    addr_valid_d   = addr_in <= otp_lock_pkg::OTP_AREA_LAST;
    serial_field_d = addr_in <= otp_lock_pkg::OTP_SERIAL_LAST;
    if (!loaded_q) begin
      factory_d = factory_lock_nv_in;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q             <= otp_lock_pkg::ST_OPCODE;
      cnt_q               <= '0;
      shift_q             <= '0;
      rd_q                <= '0;
      sdo_q               <= '0;
      oe_q                <= 1'b0;
      otp_mode_q          <= 1'b0;
      customer_lock_bit_q <= 1'b0;
      factory_q           <= 1'b0;
      loaded_q            <= 1'b0;
      nv_write_q          <= 1'b0;
      addr_valid_q        <= 1'b0;
      serial_field_q      <= 1'b0;
    end else begin
      state_q             <= state_d;
      cnt_q               <= cnt_d;
      shift_q             <= shift_d;
      rd_q                <= rd_d;
      sdo_q               <= sdo_d;
      oe_q                <= oe_d;
      otp_mode_q          <= otp_mode_d;
      // factory bit never written by instructions
      factory_q           <= factory_d;
      loaded_q            <= 1'b1;
      nv_write_q          <= nv_write_d;
      addr_valid_q        <= addr_valid_d;
      serial_field_q      <= serial_field_d;
      customer_lock_bit_q <= customer_lock_bit_d;
    end
  end

  assign sdo_out                      = sdo_q;
  assign sdo_oe_out                   = oe_q;
  // the general machinery obeys these levels; only the lock-status write is vetoed here itself
  always_comb begin
    gate_out.otp_mode           = otp_mode_q;
    gate_out.array_write_block  = otp_mode_q;
    gate_out.status_write_block = otp_mode_q;
    gate_out.otp_program_allow  = otp_mode_q & ~locked;
  end
  assign otp_addr_valid_out           = addr_valid_q;
  assign otp_serial_field_out         = serial_field_q;
  assign otp_lock_status_out          = lock_status;
  assign customer_lock_write_out      = nv_write_q;

endmodule : otp_lock_control
`default_nettype wire

/* File: bench/host_model.sv */
// host controller model that shifts single-mode or quad-mode frames
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock and returned data
  input  wire logic                clock_in,
  input  wire logic [3:0]          sdo_in,
  input  wire logic                quad_in,
  // serial lines to the device
  output var otp_lock_pkg::serial_in_s serial_out
);
  initial serial_out = '{cs_n: 1'b1, strobe: 1'b0, data: 4'h0};
  task automatic frame(input logic [23:0] v, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    for (int i = 0; i <= n; i++) begin
      @(posedge clock_in);
      // msb first
      // n counts strobes; a quad frame carries at most six nibbles of v
      if (i < n && quad_in) serial_out <= '{cs_n: 1'b0, strobe: 1'b1, data: v[4*(n-1-i) +: 4]};
      else if (i < n) serial_out <= '{cs_n: 1'b0, strobe: 1'b1, data: {3'b000, v[n-1-i]}};
      else serial_out <= '{cs_n: 1'b0, strobe: 1'b0, data: ~serial_out.data};
      @(negedge clock_in);
      if (i > 0 && quad_in) rx = {rx[11:0], sdo_in};
      else if (i > 0) rx = {rx[14:0], sdo_in[0]};
    end
    @(posedge clock_in);
    serial_out <= '{cs_n: 1'b1, strobe: 1'b0, data: ~serial_out.data};
    @(posedge clock_in);
    @(negedge clock_in);
  endtask : frame
endmodule : host_model
`default_nettype wire

/* File: bench/otp_lock_control_sva.sv */
// port checks for the otp lock control block
`timescale 1ns/1ps
`default_nettype none
module otp_lock_control_sva (
  // observed ports
  input wire logic                     clock_in,
  input wire logic                     nrst_in,
  input wire otp_lock_pkg::serial_in_s serial_in,
  input wire logic [23:0]              addr_in,
  input wire otp_lock_pkg::gate_s      gate_out,
  input wire logic                     otp_addr_valid_out,
  input wire logic                     otp_serial_field_out,
  input wire logic [7:0]               otp_lock_status_out,
  input wire logic                     sdo_oe_out,
  input wire logic                     customer_lock_write_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  // two edges past reset, so nv load is settled
  sequence s_up2; $past(nrst_in) && $past(nrst_in, 2); endsequence
  a_array_write_block: assert property (gate_out.array_write_block == gate_out.otp_mode)
    else $error("array write block differs from otp mode");
  a_status_write_block: assert property (gate_out.status_write_block == gate_out.otp_mode)
    else $error("status write block differs from otp mode");
  a_program_allow_gate: assert property (gate_out.otp_program_allow == (gate_out.otp_mode
    && !otp_lock_status_out[0] && !otp_lock_status_out[1])) else $error("program allow wrong");
  a_reserved_read_zero: assert property (otp_lock_status_out[7:2] == 6'h00)
    else $error("reserved bits not zero");
  a_user_range: assert property (s_up2 |-> otp_addr_valid_out == ($past(addr_in) <= 24'h00_01FF))
    else $error("otp range flag wrong");
  a_serial_range: assert property (s_up2 |-> otp_serial_field_out == ($past(addr_in) <= 24'h00_000F))
    else $error("serial field flag wrong");
  a_factory_read_only: assert property (s_up2 |-> $stable(otp_lock_status_out[0]))
    else $error("factory bit changed");
  a_customer_lock_kept: assert property (otp_lock_status_out[1] |=> otp_lock_status_out[1])
    else $error("customer lock cleared");
  a_lock_commit_ok: assert property (customer_lock_write_out |-> !gate_out.otp_mode
    ##[0:1] otp_lock_status_out[1]) else $error("lock commit wrong");
  a_read_out_release: assert property (serial_in.cs_n |=> !sdo_oe_out)
    else $error("output enable after deselect");
  // a commit comes only from the first deselected edge after a selected one
  sequence s_frame_end; $past(serial_in.cs_n) && !$past(serial_in.cs_n, 2); endsequence
  a_mode_by_command: assert property ($changed(gate_out.otp_mode)
    |-> $past(!serial_in.cs_n && serial_in.strobe)) else $error("otp mode moved without a strobe");
  a_output_on_strobe: assert property ($rose(sdo_oe_out)
    |-> $past(!serial_in.cs_n && serial_in.strobe)) else $error("output enabled without a strobe");
  a_lock_set_pulse: assert property ($rose(otp_lock_status_out[1]) && $past(nrst_in)
    |-> customer_lock_write_out) else $error("customer lock set without a commit pulse");
  a_commit_on_boundary: assert property (customer_lock_write_out |-> s_frame_end)
    else $error("lock commit outside a frame end");
endmodule : otp_lock_control_sva
bind otp_lock_control otp_lock_control_sva i_sva (.clock_in, .nrst_in, .serial_in, .addr_in,
  .gate_out, .otp_addr_valid_out, .otp_serial_field_out, .otp_lock_status_out, .sdo_oe_out,
  .customer_lock_write_out);
`default_nettype wire

/* File: bench/tb_top.sv */
// self-checking bench for the otp lock control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                     clock_in = 1'b0;
  logic                     nrst_in = 1'b0;
  logic [1:0]               nv = 2'b00;
  logic [23:0]              addr_in = 24'h00_0000;
  otp_lock_pkg::serial_in_s serial_in;
  otp_lock_pkg::gate_s      gate_out;
  logic [3:0]               sdo_out;
  logic [7:0]               stat;
  logic [15:0]              rx;
  logic                     oe;
  logic                     av;
  logic                     sf;
  logic                     quad = 1'b0;
  logic                     nvw;
  int                       error_cnt = 0;
  int                       cmp_count = 0;
  int                       oe_seen = 0;
  int                       nvw_seen = 0;
  int                       base_oe;
  int                       base_nvw;
  logic [23:0] aval [4] = '{24'h00_01FF, 24'h00_0200, 24'h00_000F, 24'h00_0010};
  logic [1:0]  aexp [4] = '{2'b10, 2'b00, 2'b11, 2'b10};
  initial begin
    forever #50 clock_in = ~clock_in;
  end
  // enable and commit levels are tallied once per cycle on the falling edge after the one that launches them
  always @(negedge clock_in) begin
    if (oe === 1'b1) oe_seen++;
    if (nvw === 1'b1) nvw_seen++;
  end
  host_model i_host (.clock_in, .sdo_in(sdo_out), .quad_in(quad), .serial_out(serial_in));
  otp_lock_control i_dut (.clock_in, .nrst_in, .serial_in, .quad_instruction_mode_in(quad),
    .factory_lock_nv_in(nv[0]), .customer_lock_nv_in(nv[1]), .addr_in, .sdo_out,
    .sdo_oe_out(oe), .gate_out, .otp_addr_valid_out(av), .otp_serial_field_out(sf),
    .otp_lock_status_out(stat), .customer_lock_write_out(nvw));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic do_reset(input logic [1:0] v);
    @(posedge clock_in);
    nrst_in <= 1'b0;
    nv <= v;
    repeat (16) @(posedge clock_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    @(negedge clock_in);
  endtask : do_reset
  initial begin
    #5_000_000;
    error_cnt++;
    conclude();
  end
  initial begin
    do_reset(2'b00);
    base_oe = oe_seen;
    i_host.frame(24'h2B_0000, 24, rx);
    chk(rx, 16'h0000);
    chk(16'(oe_seen - base_oe), 16'h0011);
    i_host.frame(24'h00_00B1, 8, rx);
    chk(16'(gate_out), 16'h000F);
    base_nvw = nvw_seen;
    i_host.frame(24'h00_2F02, 16, rx);
    chk(16'(stat), 16'h0000);
    for (int k = 0; k < 4; k++) begin
      @(posedge clock_in);
      addr_in <= aval[k];
      @(posedge clock_in);
      @(negedge clock_in);
      chk(16'({av, sf}), 16'(aexp[k]));
    end
    i_host.frame(24'h00_00C1, 8, rx);
    chk(16'(gate_out), 16'h0000);
    i_host.frame(24'h00_5E02, 17, rx);
    i_host.frame(24'h00_1782, 15, rx);
    chk(16'(stat), 16'h0000);
    chk(16'(nvw_seen - base_nvw), 16'h0000);
    i_host.frame(24'h00_2F02, 16, rx);
    i_host.frame(24'h2B_0000, 24, rx);
    chk(rx, 16'h0202);
    chk(16'(nvw_seen - base_nvw), 16'h0001);
    @(posedge clock_in);
    quad <= 1'b1;
    i_host.frame(24'h2B_0000, 6, rx);
    chk(rx, 16'h0202);
    @(posedge clock_in);
    quad <= 1'b0;
    i_host.frame(24'h00_00B1, 8, rx);
    chk(16'(gate_out), 16'h000E);
    do_reset(2'b01);
    chk(16'(stat), 16'h0001);
    i_host.frame(24'h00_00B1, 8, rx);
    chk(16'(gate_out), 16'h000E);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
